// File: core/rssw_core.sv
// Run-state flags, one-scan initial pulse, scan watchdog and battery watch.
// Assumes a classic Wishbone master on core_clk; run and battery pins are async.
`timescale 1ns/100ps
`include "rssw_regs.svh"

// Summary of operation
// - Run flag normally-open stays high for the whole time in run mode.
// - Run flag normally-closed stays low for the whole time in run mode.
// - Initial pulse normally-open is high for exactly the first scan after start.
// - Initial pulse normally-closed is low for exactly the first scan after start.
// - Scan overrunning the limit lights the error lamp and forces all outputs off.
// - Limit register loads 200 ms at power-up, 100 ms on the short variant.
// - Software may overwrite the limit to tolerate longer scans.
// - The kick instruction restarts the watchdog count mid-scan.
// - Limit values up to 32767 ms are accepted.
// - A negative limit written is taken as zero.
// - Low backup battery lights the battery lamp.
// - With battery mode selected, low battery also lights the alarm lamp.
// - The battery latch holds once low voltage has been seen.
module rssw_core #(
	parameter bit    SHORT_LIMIT = 1'b0,
	parameter int    MS_CYCLES   = `RSSW_MS_CYC
) (
	input  wire logic                   core_clk,   // 50 MHz clock
	input  wire logic                   rst_n,      // Async reset
	input  wire logic                   wb_cyc_i,   // Bus cycle
	input  wire logic                   wb_stb_i,   // Strobe
	input  wire logic                   wb_we_i,    // Write
	input  wire logic [3:0]             wb_sel_i,   // Byte lanes
	input  wire logic [7:0]             wb_adr_i,   // Byte address
	input  wire logic [31:0]            wb_dat_i,   // Write data
	output logic      [31:0]            wb_dat_o,   // Read data
	output logic                        wb_ack_o,   // Acknowledge
	input  wire logic                   run_pin,    // RUN switch
	input  wire logic                   battery_lamp_pin,   // Low battery sense
	output rssw_pkg::rssw_flags_type    flags,      // Special flags
	output rssw_pkg::rssw_lamps_type    lamps,      // Panel lamps
	output logic      [15:0]            plc_out,    // Process outputs
	output logic                        irq         // Interrupt level
);
	import rssw_pkg::*;

	localparam logic [15:0] LIMIT_RST = SHORT_LIMIT ? `RSSW_LIMIT_ALT : `RSSW_LIMIT_DEF;

	function automatic logic [15:0] clamp_limit(input logic [15:0] v);
		// Negative becomes zero; positive fits 32767 by width
		return v[15] ? 16'h0000 : v;
	endfunction

	rssw_state_type                state_r;
	rssw_state_type                state_nxt;
	logic                          run_s1_r;
	logic                          run_s2_r;
	logic                          bat_s1_r;
	logic                          bat_s2_r;
	logic                          ack_r;
	logic                          req;
	logic                          wr;
	logic                          rd;
	logic                          bat_mode_r;
	logic [15:0]                   limit_r;
	logic [15:0]                   out_r;
	logic [15:0]                   wd_ms_r;
	logic [31:0]                   ms_cnt_r;
	logic                          tick;
	logic                          scan_end;
	logic                          kick;
	logic                          init_r;
	logic                          overrun;
	logic [`RSSW_IRQ_W-1:0]        istat_r;
	logic [`RSSW_IRQ_W-1:0]        imask_r;
	logic [`RSSW_IRQ_W-1:0]        ev;
	logic                          bat_latch_r;
	logic                          enter_run;

	// Input synchronisers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_s1_r <= 1'b0;
			run_s2_r <= 1'b0;
			bat_s1_r <= 1'b0;
			bat_s2_r <= 1'b0;
		end else begin
			run_s1_r <= run_pin;
			run_s2_r <= run_s1_r;
			bat_s1_r <= battery_lamp_pin;
			bat_s2_r <= bat_s1_r;
		end
	end

	// Bus slave: one wait state, ack for one cycle, unmapped reads zero
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	// Writes land on the edge at which the master samples ack
	assign wr  = wb_cyc_i && wb_stb_i && ack_r && wb_we_i;
	assign rd  = req && !wb_we_i;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end
	assign wb_ack_o = ack_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			unique case (wb_adr_i)
				`RSSW_CTRL_OFS:  wb_dat_o <= {31'h0000_0000, bat_mode_r};
				`RSSW_FLAGS_OFS: wb_dat_o <= {25'h000_0000, flags};
				`RSSW_LIMIT_OFS: wb_dat_o <= {16'h0000, limit_r};
				`RSSW_OUT_OFS:   wb_dat_o <= {16'h0000, out_r};
				`RSSW_ISTAT_OFS: wb_dat_o <= {29'h0000_0000, istat_r};
				`RSSW_IMASK_OFS: wb_dat_o <= {29'h0000_0000, imask_r};
				`RSSW_COUNT_OFS: wb_dat_o <= {16'h0000, wd_ms_r};
				default:         wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bat_mode_r <= 1'b0;
			limit_r    <= LIMIT_RST;
			out_r      <= 16'h0000;
			imask_r    <= '0;
		end else if (wr) begin
			if (wb_adr_i == `RSSW_CTRL_OFS && wb_sel_i[0])
				bat_mode_r <= wb_dat_i[`RSSW_CTRL_BATMODE];
			if (wb_adr_i == `RSSW_LIMIT_OFS && (&wb_sel_i[1:0]))
				limit_r <= clamp_limit(wb_dat_i[15:0]);
			if (wb_adr_i == `RSSW_OUT_OFS && (&wb_sel_i[1:0]))
				out_r <= wb_dat_i[15:0];
			if (wb_adr_i == `RSSW_IMASK_OFS && wb_sel_i[0])
				imask_r <= wb_dat_i[`RSSW_IRQ_W-1:0];
		end
	end

	assign scan_end = wr && wb_adr_i == `RSSW_SCAN_OFS && wb_sel_i[0] && wb_dat_i[`RSSW_SCAN_END];
	assign kick     = wr && wb_adr_i == `RSSW_SCAN_OFS && wb_sel_i[0] && wb_dat_i[`RSSW_SCAN_KICK];

	// Millisecond time base
	assign tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_r <= 32'h0000_0000;
		end else if (state_r != ST_RUN || scan_end || kick || tick) begin
			ms_cnt_r <= 32'h0000_0000;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
		end
	end

	// Scan watchdog: milliseconds since scan start or last kick
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_ms_r <= 16'h0000;
		end else if (state_r != ST_RUN || scan_end || kick) begin
			wd_ms_r <= 16'h0000;
		end else if (tick && wd_ms_r != 16'hFFFF) begin
			wd_ms_r <= wd_ms_r + 16'h0001;
		end
	end
	assign overrun = state_r == ST_RUN && !scan_end && !kick && wd_ms_r > limit_r;

	// Run state: fault holds until the RUN switch is turned off
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_STOP:  if (run_s2_r) state_nxt = ST_RUN;
			ST_RUN: begin
				if (!run_s2_r)
					state_nxt = ST_STOP;
				else if (overrun)
					state_nxt = ST_FAULT;
			end
			ST_FAULT: if (!run_s2_r) state_nxt = ST_STOP;
			default:  state_nxt = ST_STOP;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_STOP;
		end else begin
			state_r <= state_nxt;
		end
	end
	assign enter_run = state_r == ST_STOP && state_nxt == ST_RUN;

	// First scan marker: set on entry, dropped by the first scan end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_r <= 1'b0;
		end else if (enter_run) begin
			init_r <= 1'b1;
		end else if (scan_end || state_nxt != ST_RUN) begin
			init_r <= 1'b0;
		end
	end

	// Battery latch holds until reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bat_latch_r <= 1'b0;
		end else if (bat_s2_r) begin
			bat_latch_r <= 1'b1;
		end
	end

	// Flags, lamps and outputs all registered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '{battery_lamp_latch: 1'b0, battery_lamp_low: 1'b0, wdog_err: 1'b0,
				init_nc: 1'b1, init_no: 1'b0, run_nc: 1'b1, run_no: 1'b0};
		end else begin
			flags.run_no     <= state_nxt == ST_RUN;
			flags.run_nc     <= state_nxt != ST_RUN;
			flags.init_no    <= init_r;
			flags.init_nc    <= !init_r;
			flags.wdog_err   <= state_nxt == ST_FAULT;
			flags.battery_lamp_low   <= bat_s2_r;
			flags.battery_lamp_latch <= bat_latch_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lamps   <= '0;
			plc_out <= 16'h0000;
		end else begin
			lamps.error_lamp   <= state_nxt == ST_FAULT;
			lamps.battery_lamp <= bat_latch_r;
			lamps.alarm_lamp   <= bat_latch_r && bat_mode_r;
			plc_out            <= state_nxt == ST_RUN ? out_r : 16'h0000;
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	assign ev[`RSSW_IRQ_INIT] = enter_run;
	assign ev[`RSSW_IRQ_WDOG] = state_r == ST_RUN && state_nxt == ST_FAULT;
	assign ev[`RSSW_IRQ_BATTERY_LAMP] = bat_s2_r && !bat_latch_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			istat_r <= '0;
		end else if (wr && wb_adr_i == `RSSW_ISTAT_OFS && wb_sel_i[0]) begin
			istat_r <= ev | (istat_r & ~wb_dat_i[`RSSW_IRQ_W-1:0]);
		end else begin
			istat_r <= ev | istat_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat_r & imask_r);
		end
	end

	// Assertions
	sequence s_enter;
		$rose(flags.run_no);
	endsequence

	sequence s_first_scan_end;
		scan_end && state_r == ST_RUN && run_s2_r;
	endsequence

	AST_RUN_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
		flags.run_no != flags.run_nc)
		else $error("run flags not complementary");

	AST_STOP_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == ST_STOP && !run_s2_r |=> !flags.run_no && flags.run_nc)
		else $error("stop mode flags wrong");

	AST_INIT_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_enter |=> flags.init_no)
		else $error("initial pulse missing after run entry");

	AST_INIT_FALL: assert property (@(posedge core_clk) disable iff (!rst_n)
		flags.init_no ##0 s_first_scan_end |=> ##1 flags.init_nc && !flags.init_no)
		else $error("initial pulse outlasts first scan");

	AST_INIT_NC: assert property (@(posedge core_clk) disable iff (!rst_n)
		flags.init_no == !flags.init_nc)
		else $error("initial pulse pair inconsistent");

	AST_OVERRUN: assert property (@(posedge core_clk) disable iff (!rst_n)
		overrun && run_s2_r |=> lamps.error_lamp && plc_out == 16'h0000 && !flags.run_no)
		else $error("overrun not handled");

	AST_KICK: assert property (@(posedge core_clk) disable iff (!rst_n)
		kick |=> wd_ms_r == 16'h0000 && ms_cnt_r == 32'h0000_0000)
		else $error("kick did not restart count");

	AST_NEG_LIMIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr && wb_adr_i == `RSSW_LIMIT_OFS && (&wb_sel_i[1:0]) && wb_dat_i[15] |=> limit_r == 16'h0000)
		else $error("negative limit not zeroed");

	AST_LIMIT_MAX: assert property (@(posedge core_clk) disable iff (!rst_n)
		limit_r <= `RSSW_LIMIT_MAX)
		else $error("limit above maximum");

	AST_BATTERY_LAMP: assert property (@(posedge core_clk) disable iff (!rst_n)
		bat_s2_r |=> ##1 lamps.battery_lamp && (lamps.alarm_lamp == $past(bat_mode_r)))
		else $error("battery lamps wrong");

	AST_BATTERY_LAMP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		flags.battery_lamp_latch |=> flags.battery_lamp_latch)
		else $error("battery latch dropped");

	AST_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");

	AST_RUN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == ST_RUN && run_s2_r && !overrun |=> flags.run_no && !flags.run_nc)
		else $error("run flag dropped while running");

	AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == ST_FAULT |-> lamps.error_lamp && flags.wdog_err && plc_out == 16'h0000 && !flags.run_no)
		else $error("fault state outputs wrong");

	AST_PLC_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == ST_STOP |-> plc_out == 16'h0000)
		else $error("outputs driven in stop mode");

	AST_ALARM_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
		!bat_mode_r |=> !lamps.alarm_lamp)
		else $error("alarm lamp lit without battery mode");

	AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
		(|(istat_r & imask_r)) |=> irq)
		else $error("interrupt missing");

	AST_IRQ_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(|(istat_r & imask_r)) |=> !irq)
		else $error("interrupt without cause");

	AST_ISTAT_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
		ev != '0 |=> (istat_r & $past(ev)) == $past(ev))
		else $error("status event lost");
endmodule

// File: core/rssw_regs.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Assumes a 32-bit Wishbone slave and a 50 MHz core clock.
`ifndef RSSW_REGS_SVH
`define RSSW_REGS_SVH
`define RSSW_ADR_W        8
`define RSSW_CTRL_OFS     8'h00
`define RSSW_FLAGS_OFS    8'h04
`define RSSW_LIMIT_OFS    8'h08
`define RSSW_SCAN_OFS     8'h0C
`define RSSW_OUT_OFS      8'h10
`define RSSW_ISTAT_OFS    8'h14
`define RSSW_IMASK_OFS    8'h18
`define RSSW_COUNT_OFS    8'h1C
`define RSSW_CTRL_BATMODE 0
`define RSSW_SCAN_END     0
`define RSSW_SCAN_KICK    1
`define RSSW_IRQ_INIT     0
`define RSSW_IRQ_WDOG     1
`define RSSW_IRQ_BATTERY_LAMP     2
`define RSSW_IRQ_W        3
`define RSSW_LIMIT_DEF    16'h00C8
`define RSSW_LIMIT_ALT    16'h0064
`define RSSW_LIMIT_MAX    16'h7FFF
`define RSSW_CLK_NS       20
`define RSSW_MS_NS        1000000
`define RSSW_MS_CYC       (`RSSW_MS_NS / `RSSW_CLK_NS)
`endif

// File: core/rssw_pkg.sv
// Types shared by the run-status and scan-watchdog supervisor.
// Assumes rssw_regs.svh carries every number.
package rssw_pkg;
	typedef enum logic [2:0] {
		ST_STOP  = 3'b001,
		ST_RUN   = 3'b010,
		ST_FAULT = 3'b100
	} rssw_state_type;

	typedef struct packed {
		logic battery_lamp_latch;
		logic battery_lamp_low;
		logic wdog_err;
		logic init_nc;
		logic init_no;
		logic run_nc;
		logic run_no;
	} rssw_flags_type;

	typedef struct packed {
		logic error_lamp;
		logic battery_lamp;
		logic alarm_lamp;
	} rssw_lamps_type;
endpackage

// File: bench/run_status_and_scan_watchdog_tb.sv
// Self-checking bench for the run-status and scan-watchdog supervisor.
// Assumes rssw_core and rssw_regs.svh from core/; one ms shortened to 10 cycles.
`timescale 1ns/100ps
`include "rssw_regs.svh"
module run_status_and_scan_watchdog_tb;
	import rssw_pkg::*;
	localparam int MS = 10;
	logic                 core_clk   = 1'b0;
	logic                 rst_n      = 1'b0;
	logic                 wb_cyc_i   = 1'b0;
	logic                 wb_stb_i   = 1'b0;
	logic                 wb_we_i    = 1'b0;
	logic [3:0]           wb_sel_i   = 4'h0;
	logic [7:0]           wb_adr_i   = 8'h00;
	logic [31:0]          wb_dat_i   = 32'h0000_0000;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	logic                 run_pin    = 1'b0;
	logic                 battery_lamp_pin   = 1'b0;
	rssw_flags_type       flags;
	rssw_lamps_type       lamps;
	logic [15:0]          plc_out;
	logic                 irq;
	int                   num_errors = 0;
	int                   compares   = 0;
	int                   cycles     = 0;
	logic [31:0]          rd;

	always #10 core_clk = ~core_clk;

	rssw_core #(.SHORT_LIMIT(1'b0), .MS_CYCLES(MS)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_pin(run_pin), .battery_lamp_pin(battery_lamp_pin),
		.flags(flags), .lamps(lamps), .plc_out(plc_out), .irq(irq)
	);

	task automatic report_and_stop();
		$display("Counts: %0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Classic single cycle; holds the request until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		check(32'(wb_ack_o), 32'h0000_0001, "bus ack");
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_xfer(1'b1, adr, dat);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
		wb_xfer(1'b0, adr, 32'h0000_0000);
		check(rd, exp, what);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: run took too long", $time);
			report_and_stop();
		end
	end

	initial begin
		wait_cyc(10);
		rst_n <= 1'b1;
		check(32'(flags), 32'h0000_000A, "stop flags");
		check(32'(lamps), 32'h0000_0000, "reset lamps");
		rd_chk(`RSSW_LIMIT_OFS, 32'h0000_00C8, "default limit");
		wr(`RSSW_LIMIT_OFS, 32'h0000_7FFF);
		rd_chk(`RSSW_LIMIT_OFS, 32'h0000_7FFF, "max limit");
		wr(`RSSW_LIMIT_OFS, 32'h0000_8001);
		rd_chk(`RSSW_LIMIT_OFS, 32'h0000_0000, "negative limit");
		wr(`RSSW_LIMIT_OFS, 32'h0000_00C8);
		$display("test limit register done");

		wr(`RSSW_IMASK_OFS, 32'h0000_0001);
		run_pin <= 1'b1;
		wait_cyc(8);
		check(32'(flags), 32'h0000_0005, "run entry flags");
		check(32'(irq), 32'h0000_0001, "run entry irq");
		wr(`RSSW_ISTAT_OFS, 32'h0000_0001);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0000, "irq cleared");
		for (int i = 0; i < 2; i++) begin
			wr(`RSSW_SCAN_OFS, 32'h0000_0001);
			wait_cyc(3);
			check(32'(flags), 32'h0000_0009, "after scan end");
		end
		$display("test run entry done");

		wr(`RSSW_OUT_OFS, 32'h0000_1234);
		wait_cyc(2);
		check(32'(plc_out), 32'h0000_1234, "outputs while running");
		wr(`RSSW_IMASK_OFS, 32'h0000_0002);
		wr(`RSSW_SCAN_OFS, 32'h0000_0002);
		wr(`RSSW_LIMIT_OFS, 32'h0000_0002);
		// Kicks about every 1.1 ms keep a 2 ms limit from running out
		for (int i = 0; i < 12; i++) begin
			wr(`RSSW_SCAN_OFS, 32'h0000_0002);
			wait_cyc(8);
		end
		check(32'(lamps.error_lamp), 32'h0000_0000, "no fault while kicked");
		check(32'(plc_out), 32'h0000_1234, "outputs kept while kicked");
		wait_cyc(12);
		rd_chk(`RSSW_COUNT_OFS, 32'h0000_0002, "ms since kick");
		wait_cyc(45);
		check(32'(lamps.error_lamp), 32'h0000_0001, "overrun lamp");
		check(32'(plc_out), 32'h0000_0000, "outputs forced off");
		check(32'(flags.wdog_err), 32'h0000_0001, "overrun flag");
		check(32'(irq), 32'h0000_0001, "overrun irq");
		wr(`RSSW_IMASK_OFS, 32'h0000_0000);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0000, "irq masked");
		rd_chk(`RSSW_ISTAT_OFS, 32'h0000_0002, "overrun status");
		wr(`RSSW_ISTAT_OFS, 32'h0000_0002);
		rd_chk(`RSSW_ISTAT_OFS, 32'h0000_0000, "status cleared");
		$display("test watchdog done");

		run_pin <= 1'b0;
		wait_cyc(6);
		check(32'(flags.run_no), 32'h0000_0000, "stop run flag");
		check(32'(flags.run_nc), 32'h0000_0001, "stop run complement");
		$display("test stop done");

		battery_lamp_pin <= 1'b1;
		wait_cyc(6);
		check(32'(lamps.battery_lamp), 32'h0000_0001, "battery lamp");
		check(32'(lamps.alarm_lamp), 32'h0000_0000, "alarm off without mode");
		battery_lamp_pin <= 1'b0;
		wait_cyc(6);
		check(32'(flags.battery_lamp_latch), 32'h0000_0001, "battery latch held");
		check(32'(lamps.battery_lamp), 32'h0000_0001, "battery lamp held");
		wr(`RSSW_CTRL_OFS, 32'h0000_0001);
		wait_cyc(3);
		check(32'(lamps.alarm_lamp), 32'h0000_0001, "alarm with mode");
		rd_chk(`RSSW_ISTAT_OFS, 32'h0000_0004, "battery status");
		rd_chk(`RSSW_FLAGS_OFS, 32'h0000_004A, "stop flags with latch");
		$display("test battery done");

		wr(8'h40, 32'hFFFF_FFFF);
		rd_chk(8'h40, 32'h0000_0000, "unmapped read");
		rd_chk(`RSSW_LIMIT_OFS, 32'h0000_0002, "limit untouched");
		$display("test unmapped done");
		report_and_stop();
	end
endmodule
